// [src/rws_pkg.sv]
// constants and helpers for the reset and watchdog supervisor
package rws_pkg;

    // timing base
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_PERIOD_NS = 1_000_000;
    localparam int TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_CNT_W     = 17;

    // debounce time in ms ticks
    localparam int           DEBOUNCE_MS    = 10;
    localparam logic [3:0]   DEBOUNCE_TICKS = 4'(DEBOUNCE_MS);

    // reset hold times in ms
    localparam logic [10:0]  HOLD_0_MS = 11'h032;
    localparam logic [10:0]  HOLD_1_MS = 11'h0C8;
    localparam logic [10:0]  HOLD_2_MS = 11'h190;
    localparam logic [10:0]  HOLD_3_MS = 11'h320;

    // watchdog intervals in ms, code 3 is off
    localparam logic [10:0]  WD_0_MS   = 11'h019;
    localparam logic [10:0]  WD_1_MS   = 11'h0C8;
    localparam logic [10:0]  WD_2_MS   = 11'h578;
    localparam logic [1:0]   WD_SEL_OFF = 2'h3;

    // register byte addresses
    localparam logic [3:0]   REG_CTRL       = 4'h0;
    localparam logic [3:0]   REG_STATUS     = 4'h4;
    localparam logic [3:0]   REG_IRQ_STATUS = 4'h8;
    localparam logic [3:0]   REG_IRQ_MASK   = 4'hC;

    // control fields and reset values
    localparam int           CTRL_HOLD_LSB  = 0;
    localparam int           CTRL_WD_LSB    = 2;
    localparam logic [1:0]   HOLD_SEL_RST   = 2'h0;
    localparam logic [1:0]   WD_SEL_RST     = 2'h3;

    // status bits
    localparam int           ST_MAIN_OK     = 0;
    localparam int           ST_SECOND_OK   = 1;
    localparam int           ST_THIRD_OK    = 2;
    localparam int           ST_MANUAL_N    = 3;
    localparam int           ST_WD_EXPIRED  = 4;
    localparam int           ST_SYS_RESET   = 5;

    // interrupt bits
    localparam int           IRQ_W          = 5;
    localparam int           IRQ_MAIN_LOW   = 0;
    localparam int           IRQ_SECOND     = 1;
    localparam int           IRQ_THIRD      = 2;
    localparam int           IRQ_WATCHDOG   = 3;
    localparam int           IRQ_MANUAL     = 4;
    localparam logic [4:0]   IRQ_MASK_RST   = 5'h00;

    typedef enum logic {RST_HOLD, RST_RUN} rws_rst_state_t;

    function automatic logic [10:0] hold_ticks(input logic [1:0] sel);
        case (sel)
            2'h0:    hold_ticks = HOLD_0_MS;
            2'h1:    hold_ticks = HOLD_1_MS;
            2'h2:    hold_ticks = HOLD_2_MS;
            default: hold_ticks = HOLD_3_MS;
        endcase
    endfunction

    function automatic logic [10:0] wd_ticks(input logic [1:0] sel);
        case (sel)
            2'h0:    wd_ticks = WD_0_MS;
            2'h1:    wd_ticks = WD_1_MS;
            default: wd_ticks = WD_2_MS;
        endcase
    endfunction

endpackage

// [src/rws_debounce.sv]
// manual reset debouncer: low passes at once, high must stay stable
module rws_debounce
    import rws_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_nrst,
    input  wire logic i_tick,
    input  wire logic i_raw_n,
    output logic      o_clean_n
);

    logic [3:0] stable_cnt;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_clean_n  <= 1'b1;
            stable_cnt <= 4'h0;
        end
        else if (!i_raw_n)
        begin
            o_clean_n  <= 1'b0;
            stable_cnt <= 4'h0;
        end
        else if (!o_clean_n && i_tick)
        begin
            if (stable_cnt == DEBOUNCE_TICKS - 4'h1)
                o_clean_n <= 1'b1;
            stable_cnt <= stable_cnt + 4'h1;
        end
    end

endmodule // rws_debounce

// [src/rws_supervisor.sv]
// reset and watchdog supervisor core with avalon register slave
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
module rws_supervisor
    import rws_pkg::*;
#(
    parameter int   P_TICK_CYCLES       = TICK_CYCLES,
    parameter bit   P_RESET_ACTIVE_HIGH = 1'b0
)
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_main_supply_above,
    input  wire logic        i_second_supply_sense,
    input  wire logic        i_third_supply_sense,
    input  wire logic        i_manual_reset_n,
    input  wire logic        i_wd_sda,
    input  wire logic        i_wd_scl,
    input  wire logic [1:0]  i_nv_wd_sel,
    output logic [1:0]       o_nv_wd_sel,
    output logic             o_nv_store,
    output logic             o_sys_reset_out,
    output logic             o_sys_reset_oe_n,
    output logic             o_early_low_supply_n,
    output logic             o_second_supply_fail_n,
    output logic             o_third_supply_fail_n,
    output logic             o_watchdog_timeout_n,
    output logic             o_irq
);

    logic [TICK_CNT_W-1:0] tick_cnt;
    logic                  tick;
    logic                  mr_clean_n;
    rws_rst_state_t        rst_state;
    logic [10:0]           hold_cnt;
    logic                  rst_active;
    logic                  rst_cause;
    logic [1:0]            hold_sel;
    logic [1:0]            wd_sel;
    logic                  nv_loaded;
    logic [10:0]           wd_cnt;
    logic                  wd_expired;
    logic                  sda_prev;
    logic                  scl_prev;
    logic                  restart_armed;
    logic                  wd_restart;
    logic                  bus_acc;
    logic                  wr_ctrl;
    logic                  wr_irq_stat;
    logic                  wr_irq_mask;
    logic [IRQ_W-1:0]      cond;
    logic [IRQ_W-1:0]      cond_prev;
    logic [IRQ_W-1:0]      irq_stat;
    logic [IRQ_W-1:0]      irq_mask;
    logic [IRQ_W-1:0]      next_irq_stat;
    logic [7:0]            status_byte;
    logic [31:0]           next_readdata;

    // free-running ms tick
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end
        else if (tick_cnt == TICK_CNT_W'(P_TICK_CYCLES - 1))
        begin
            tick_cnt <= '0;
            tick     <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + TICK_CNT_W'(1);
            tick     <= 1'b0;
        end
    end

    rws_debounce u_debounce (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_tick    (tick),
        .i_raw_n   (i_manual_reset_n),
        .o_clean_n (mr_clean_n)
    );

    // system reset sequencing
    assign rst_cause  = !i_main_supply_above || !mr_clean_n;
    assign rst_active = (rst_state == RST_HOLD);

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            rst_state <= RST_HOLD;
            hold_cnt  <= 11'h000;
        end
        else if (rst_cause)
        begin
            rst_state <= RST_HOLD;
            hold_cnt  <= 11'h000;
        end
        else
        begin
            case (rst_state)
                RST_HOLD:
                begin
                    if (tick)
                    begin
                        hold_cnt <= hold_cnt + 11'h001;
                        if (hold_cnt + 11'h001 == hold_ticks(hold_sel))
                            rst_state <= RST_RUN;
                    end
                end
                default:
                    rst_state <= RST_RUN;
            endcase
        end
    end

    // reset pin drive
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_sys_reset_out  <= P_RESET_ACTIVE_HIGH;
            o_sys_reset_oe_n <= 1'b0;
        end
        else if (P_RESET_ACTIVE_HIGH)
        begin
            o_sys_reset_out  <= rst_active;
            o_sys_reset_oe_n <= 1'b0;
        end
        else
        begin
            o_sys_reset_out  <= 1'b0;
            o_sys_reset_oe_n <= !rst_active;
        end
    end

    // supply flags, no hold extension
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_early_low_supply_n   <= 1'b0;
            o_second_supply_fail_n <= 1'b0;
            o_third_supply_fail_n  <= 1'b0;
        end
        else
        begin
            o_early_low_supply_n   <= i_main_supply_above;
            o_second_supply_fail_n <= i_second_supply_sense;
            o_third_supply_fail_n  <= i_third_supply_sense;
        end
    end

    // watchdog restart: sda falls with scl, then stop
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            sda_prev      <= 1'b1;
            scl_prev      <= 1'b1;
            restart_armed <= 1'b0;
            wd_restart    <= 1'b0;
        end
        else
        begin
            sda_prev   <= i_wd_sda;
            scl_prev   <= i_wd_scl;
            wd_restart <= 1'b0;
            if (sda_prev && !i_wd_sda && scl_prev && !i_wd_scl)
                restart_armed <= 1'b1;
            else if (restart_armed && scl_prev && i_wd_scl && !sda_prev && i_wd_sda)
            begin
                restart_armed <= 1'b0;
                wd_restart    <= 1'b1;
            end
        end
    end

    // watchdog counter
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            wd_cnt     <= 11'h000;
            wd_expired <= 1'b0;
        end
        else if (wd_sel == WD_SEL_OFF || rst_active || wd_restart)
        begin
            wd_cnt     <= 11'h000;
            wd_expired <= 1'b0;
        end
        else if (tick && !wd_expired)
        begin
            wd_cnt <= wd_cnt + 11'h001;
            if (wd_cnt + 11'h001 == wd_ticks(wd_sel))
                wd_expired <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
            o_watchdog_timeout_n <= 1'b1;
        else
            o_watchdog_timeout_n <= !wd_expired;
    end

    // avalon slave handshake
    assign bus_acc     = (i_avs_read || i_avs_write) && o_avs_waitrequest;
    assign wr_ctrl     = bus_acc && i_avs_write && i_avs_byteenable[0] && i_avs_address == REG_CTRL;
    assign wr_irq_stat = bus_acc && i_avs_write && i_avs_byteenable[0] && i_avs_address == REG_IRQ_STATUS;
    assign wr_irq_mask = bus_acc && i_avs_write && i_avs_byteenable[0] && i_avs_address == REG_IRQ_MASK;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h00000000;
        end
        else if (bus_acc)
        begin
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata    <= i_avs_read ? next_readdata : 32'h00000000;
        end
        else
            o_avs_waitrequest <= 1'b1;
    end

    // control register and nonvolatile watchdog setting
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            hold_sel    <= HOLD_SEL_RST;
            wd_sel      <= WD_SEL_RST;
            nv_loaded   <= 1'b0;
            o_nv_wd_sel <= WD_SEL_RST;
            o_nv_store  <= 1'b0;
        end
        else
        begin
            o_nv_store <= 1'b0;
            if (!nv_loaded)
            begin
                nv_loaded   <= 1'b1;
                wd_sel      <= i_nv_wd_sel;
                o_nv_wd_sel <= i_nv_wd_sel;
            end
            else if (wr_ctrl)
            begin
                hold_sel    <= i_avs_writedata[CTRL_HOLD_LSB +: 2];
                wd_sel      <= i_avs_writedata[CTRL_WD_LSB +: 2];
                o_nv_wd_sel <= i_avs_writedata[CTRL_WD_LSB +: 2];
                o_nv_store  <= 1'b1;
            end
        end
    end

    // interrupt events on condition onset, set wins over clear
    always_comb
    begin
        cond                = '0;
        cond[IRQ_MAIN_LOW]  = !i_main_supply_above;
        cond[IRQ_SECOND]    = !i_second_supply_sense;
        cond[IRQ_THIRD]     = !i_third_supply_sense;
        cond[IRQ_WATCHDOG]  = wd_expired;
        cond[IRQ_MANUAL]    = !mr_clean_n;
        next_irq_stat       = irq_stat;
        if (wr_irq_stat)
            next_irq_stat = irq_stat & ~i_avs_writedata[IRQ_W-1:0];
        next_irq_stat = next_irq_stat | (cond & ~cond_prev);
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            cond_prev <= '0;
            irq_stat  <= '0;
            irq_mask  <= IRQ_MASK_RST;
            o_irq     <= 1'b0;
        end
        else
        begin
            cond_prev <= cond;
            irq_stat  <= next_irq_stat;
            if (wr_irq_mask)
                irq_mask <= i_avs_writedata[IRQ_W-1:0];
            o_irq <= |(irq_stat & irq_mask);
        end
    end

    // read decode
    always_comb
    begin
        status_byte                = 8'h00;
        status_byte[ST_MAIN_OK]    = i_main_supply_above;
        status_byte[ST_SECOND_OK]  = i_second_supply_sense;
        status_byte[ST_THIRD_OK]   = i_third_supply_sense;
        status_byte[ST_MANUAL_N]   = mr_clean_n;
        status_byte[ST_WD_EXPIRED] = wd_expired;
        status_byte[ST_SYS_RESET]  = rst_active;
        if (i_avs_address == REG_CTRL)
            next_readdata = {28'h0000000, wd_sel, hold_sel};
        else if (i_avs_address == REG_STATUS)
            next_readdata = {24'h000000, status_byte};
        else if (i_avs_address == REG_IRQ_STATUS)
            next_readdata = {27'h0000000, irq_stat};
        else if (i_avs_address == REG_IRQ_MASK)
            next_readdata = {27'h0000000, irq_mask};
        else
            next_readdata = 32'h00000000;
    end

    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    sequence s_restart_arm;
        sda_prev && !i_wd_sda && scl_prev && !i_wd_scl;
    endsequence

    sequence s_stop;
        scl_prev && i_wd_scl && !sda_prev && i_wd_sda;
    endsequence

    property p_manual_asserts;
        !mr_clean_n |=> rst_active ##1 (P_RESET_ACTIVE_HIGH ? o_sys_reset_out : !o_sys_reset_oe_n);
    endproperty
    a_manual_asserts: assert property (p_manual_asserts) else $error("manual reset did not assert reset");

    property p_main_low;
        !i_main_supply_above |=> rst_active && hold_cnt == 11'h000;
    endproperty
    a_main_low: assert property (p_main_low) else $error("main low did not hold reset");

    property p_hold_release;
        $fell(rst_active) |-> hold_cnt == hold_ticks(hold_sel) && $past(tick);
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("reset released before hold time");

    property p_early_flag;
        i_nrst |=> o_early_low_supply_n == $past(i_main_supply_above);
    endproperty
    a_early_flag: assert property (p_early_flag) else $error("early low flag mismatch");

    property p_second_flag;
        i_nrst |=> o_second_supply_fail_n == $past(i_second_supply_sense);
    endproperty
    a_second_flag: assert property (p_second_flag) else $error("second fail flag mismatch");

    property p_third_flag;
        i_nrst |=> o_third_supply_fail_n == $past(i_third_supply_sense);
    endproperty
    a_third_flag: assert property (p_third_flag) else $error("third fail flag mismatch");

    property p_wd_off;
        wd_sel == WD_SEL_OFF |=> wd_cnt == 11'h000 ##1 o_watchdog_timeout_n;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("watchdog active while off");

    property p_wd_expire;
        $rose(wd_expired) |-> wd_cnt == wd_ticks(wd_sel) ##1 !o_watchdog_timeout_n;
    endproperty
    a_wd_expire: assert property (p_wd_expire) else $error("timeout at wrong count");

    property p_restart;
        s_restart_arm ##[1:300] (s_stop and restart_armed) |=> wd_restart ##1 wd_cnt == 11'h000;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not clear watchdog");

    property p_irq_level;
        ##1 o_irq == $past(|(irq_stat & irq_mask));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");

endmodule // rws_supervisor

// [sim/rws_cpu_model.sv]
// board-side model: processor watchdog restart, reset pin and setting store
module rws_cpu_model
    import rws_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_kick,
    input  wire logic       i_sys_reset_out,
    input  wire logic       i_sys_reset_oe_n,
    input  wire logic       i_nv_store,
    input  wire logic [1:0] i_nv_wd_sel,
    output logic            o_wd_sda,
    output logic            o_wd_scl,
    output logic            o_in_reset,
    output logic [1:0]      o_nv_wd_sel
);
    logic [1:0] step;

    initial
    begin
        o_wd_sda    = 1'b1;
        o_wd_scl    = 1'b1;
        step        = 2'h0;
        o_nv_wd_sel = 2'h0;
    end

    // open-drain pin with pull-up, low means reset
    assign o_in_reset = ~(i_sys_reset_oe_n ? 1'b1 : i_sys_reset_out);

    // restart: sda and scl fall together, scl rises, sda rises as stop
    always @(posedge i_clk_sys)
    begin
        case (step)
            2'h0:    {o_wd_sda, o_wd_scl, step} <= i_kick ? {2'b00, 2'h1} : {2'b11, 2'h0};
            2'h1:    {o_wd_scl, step} <= {1'b1, 2'h2};
            default: {o_wd_sda, step} <= {1'b1, 2'h0};
        endcase
    end

    // setting survives power cycles outside the block
    always @(posedge i_clk_sys)
    begin
        if (i_nv_store)
            o_nv_wd_sel <= i_nv_wd_sel;
    end
endmodule // rws_cpu_model

// [sim/rws_supervisor_tb_top.sv]
// testbench for the reset and watchdog supervisor
module rws_supervisor_tb_top
    import rws_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 10;

    logic        clk_sys, nrst, rd, wr, main_ok, sec_ok, thr_ok, man_n, kick;
    logic [3:0]  addr, be;
    logic [31:0] wdata;
    wire  [31:0] rdata;
    wire  [1:0]  nv_out, nv_mem;
    wire         wait_req, nv_store, rst_out, rst_oe_n, early_n, sec_n, thr_n, wd_to_n, irq;
    wire         sda, scl, in_reset;
    int          error_cnt, num_checks;
    int          hold_ms[4] = '{int'(HOLD_0_MS), int'(HOLD_1_MS), int'(HOLD_2_MS), int'(HOLD_3_MS)};
    int          wd_ms[3]   = '{int'(WD_0_MS), int'(WD_1_MS), int'(WD_2_MS)};

    rws_supervisor #(.P_TICK_CYCLES(TICK), .P_RESET_ACTIVE_HIGH(1'b0)) i_rws_supervisor (
        .i_clk_sys(clk_sys), .i_nrst(nrst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
        .i_main_supply_above(main_ok), .i_second_supply_sense(sec_ok), .i_third_supply_sense(thr_ok),
        .i_manual_reset_n(man_n), .i_wd_sda(sda), .i_wd_scl(scl), .i_nv_wd_sel(nv_mem), .o_nv_wd_sel(nv_out),
        .o_nv_store(nv_store), .o_sys_reset_out(rst_out), .o_sys_reset_oe_n(rst_oe_n),
        .o_early_low_supply_n(early_n), .o_second_supply_fail_n(sec_n), .o_third_supply_fail_n(thr_n),
        .o_watchdog_timeout_n(wd_to_n), .o_irq(irq));

    rws_cpu_model i_rws_cpu_model (
        .i_clk_sys(clk_sys), .i_kick(kick), .i_sys_reset_out(rst_out), .i_sys_reset_oe_n(rst_oe_n),
        .i_nv_store(nv_store), .i_nv_wd_sel(nv_out), .o_wd_sda(sda), .o_wd_scl(scl),
        .o_in_reset(in_reset), .o_nv_wd_sel(nv_mem));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic fail(input string msg);
        error_cnt++;
        $display("Error at %0t ns: %s", $time, msg);
    endtask

    task automatic check_bit(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) fail(msg);
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) fail($sformatf("%s got %0h exp %0h", msg, got, exp));
    endtask

    task automatic check_range(input int got, input int lo, input int hi, input string msg);
        num_checks++;
        if (got < lo || got > hi) fail($sformatf("%s took %0d cycles", msg, got));
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // avalon access: hold until waitrequest sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        rd    <= ~w;
        wr    <= w;
        addr  <= a;
        wdata <= d;
        be    <= b;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (wait_req !== 1'b0 && n < 50);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 50) fail("bus timeout");
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string msg);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, 4'hF, q);
        check_word(q, exp, msg);
    endtask

    task automatic wait_for(input bit wd, input logic lvl, output int n);
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while ((wd ? wd_to_n : in_reset) !== lvl && n < 20000);
    endtask

    task automatic do_kick();
        kick <= 1'b1;
        @(posedge clk_sys);
        kick <= 1'b0;
        tick(6);
    endtask

    task automatic t_power_up();
        int n;
        check_bit(in_reset, 1'b1, "no power-up reset");
        wait_for(1'b0, 1'b0, n);
        check_range(n, (hold_ms[0] - 1) * TICK, hold_ms[0] * TICK + 5, "power-up hold");
        rd_chk(REG_CTRL, 32'h0000_0000, "ctrl after power-up");
        rd_chk(4'h1, 32'h0000_0000, "unmapped read");
        wr_reg(REG_CTRL, 32'h0000_000C);
        tick(3);
        check_word({30'h0, nv_mem}, 32'h0000_0003, "setting not stored");
    endtask

    task automatic t_supply();
        int n;
        sec_ok <= 1'b0;
        thr_ok <= 1'b0;
        tick(2);
        check_bit(sec_n, 1'b0, "second flag not low");
        check_bit(thr_n, 1'b0, "third flag not low");
        check_bit(in_reset, 1'b0, "reset from second supply");
        sec_ok <= 1'b1;
        thr_ok <= 1'b1;
        main_ok <= 1'b0;
        tick(2);
        check_bit(sec_n, 1'b1, "second flag not high");
        check_bit(thr_n, 1'b1, "third flag not high");
        check_bit(early_n, 1'b0, "early flag not low");
        tick(100);
        check_bit(in_reset, 1'b1, "no reset on main low");
        rd_chk(REG_STATUS, 32'h0000_002E, "status in main low");
        main_ok <= 1'b1;
        tick(2);
        check_bit(early_n, 1'b1, "early flag held");
        wait_for(1'b0, 1'b0, n);
        check_range(n, (hold_ms[0] - 1) * TICK - 2, hold_ms[0] * TICK + 5, "main recovery hold");
    endtask

    task automatic t_irq();
        logic [31:0] q;
        wr_reg(REG_IRQ_STATUS, 32'h0000_001F);
        wr_reg(REG_IRQ_MASK, 32'h0000_0002);
        thr_ok <= 1'b0;
        tick(4);
        check_bit(irq, 1'b0, "masked event raised irq");
        sec_ok <= 1'b0;
        tick(4);
        check_bit(irq, 1'b1, "irq not raised");
        rd_chk(REG_IRQ_STATUS, 32'h0000_0006, "irq status");
        rd_chk(REG_STATUS, 32'h0000_0009, "status");
        sec_ok <= 1'b1;
        thr_ok <= 1'b1;
        bus(1'b1, REG_IRQ_STATUS, 32'h0000_0004, 4'h0, q);
        wr_reg(REG_IRQ_STATUS, 32'h0000_0002);
        tick(3);
        check_bit(irq, 1'b0, "irq not cleared");
        rd_chk(REG_IRQ_STATUS, 32'h0000_0004, "w1c or byteenable");
    endtask

    task automatic t_manual(input int h);
        int n;
        int bad;
        bad = 0;
        wr_reg(REG_CTRL, 32'(12 + h));
        man_n <= 1'b0;
        tick(4);
        check_bit(in_reset, 1'b1, "manual press no reset");
        for (int i = 0; i < 8; i++)
        begin
            man_n <= i[0];
            @(posedge clk_sys);
            if (in_reset !== 1'b1) bad++;
        end
        man_n <= 1'b1;
        wait_for(1'b0, 1'b0, n);
        check_range(bad, 0, 0, "bounce released reset");
        check_range(n, (hold_ms[h] + DEBOUNCE_MS - 2) * TICK, (hold_ms[h] + DEBOUNCE_MS) * TICK + 5,
                    "manual hold");
    endtask

    task automatic t_watchdog();
        int n;
        for (int c = 0; c < 3; c++)
        begin
            wr_reg(REG_CTRL, 32'(c * 4));
            do_kick();
            wait_for(1'b1, 1'b0, n);
            check_range(n, (wd_ms[c] - 1) * TICK - 6, wd_ms[c] * TICK + 15, "watchdog interval");
            check_word({30'h0, nv_mem}, 32'(c), "setting not stored");
        end
        wr_reg(REG_CTRL, 32'h0000_000C);
        tick(3);
        check_bit(wd_to_n, 1'b1, "timeout kept when off");
        tick(400);
        check_bit(wd_to_n, 1'b1, "timeout while off");
        wr_reg(REG_CTRL, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            do_kick();
            tick(150);
            check_bit(wd_to_n, 1'b1, "restart not seen");
        end
        tick(150);
        check_bit(wd_to_n, 1'b0, "no timeout without restart");
        rd_chk(REG_STATUS, 32'h0000_001F, "status when expired");
        do_kick();
        check_bit(wd_to_n, 1'b1, "restart did not clear");
    endtask

    task automatic t_power_cycle();
        int n;
        wr_reg(REG_CTRL, 32'h0000_0004);
        tick(2);
        nrst <= 1'b0;
        tick(3);
        nrst <= 1'b1;
        check_bit(in_reset, 1'b1, "no reset after power cycle");
        wait_for(1'b0, 1'b0, n);
        check_range(n, (hold_ms[0] - 1) * TICK, hold_ms[0] * TICK + 5, "power cycle hold");
        rd_chk(REG_CTRL, 32'h0000_0004, "setting lost over power cycle");
    endtask

    initial
    begin
        #600_000;
        error_cnt++;
        $display("Error at %0t ns: run took too long", $time);
        complete_run();
    end

    initial
    begin
        {nrst, rd, wr, kick} = 4'h0;
        {main_ok, sec_ok, thr_ok, man_n} = 4'hF;
        addr = 4'h0;
        be = 4'hF;
        wdata = 32'h0000_0000;
        tick(3);
        nrst <= 1'b1;
        t_power_up();
        t_supply();
        t_irq();
        for (int h = 0; h < 4; h++) t_manual(h);
        t_watchdog();
        t_power_cycle();
        complete_run();
    end
endmodule // rws_supervisor_tb_top
